//--- verilog/scsf_pkg.sv
// Shared constants and carriers for the smart card status and format block
package scsf_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_TDR = 3'h0;
  localparam logic [2:0] ADDR_RDR = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_MODE = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  // Status bit positions
  localparam int STS_TRANSMIT_BUFFER_EMPTY_FLAG = 7;
  localparam int STS_ERS = 4;
  localparam int STS_PER = 3;
  localparam int STS_TRANSMIT_END_FLAG = 2;
  localparam int STS_MPB = 1;
  localparam int STS_TRANSMIT_MULTIPROCESSOR_BIT = 0;
  // Mode register bit positions and reserved-ones mask
  localparam int MODE_DIR = 3;
  localparam int MODE_INV = 2;
  localparam int MODE_CARD_INTERFACE_MODE_SELECT = 0;
  localparam logic [7:0] MODE_RSVD_ONES = 8'hf2;
  // Control register bit positions
  localparam int CTRL_TE = 0;
  localparam int CTRL_GM = 1;
  localparam int CTRL_BLK = 2;
  localparam int CTRL_ODD = 3;
  localparam int CTRL_SEVEN = 4;
  // Guard interval to transmit end, in half-etu ticks (2.5, 1.5, 1.0 etu)
  localparam logic [2:0] HALF_ETU_NORMAL = 3'h5;
  localparam logic [2:0] HALF_ETU_BLOCK = 3'h3;
  localparam logic [2:0] HALF_ETU_GUARD = 3'h2;
  // Reset values
  localparam logic RST_TRANSMIT_BUFFER_EMPTY_FLAG = 1'b1;
  localparam logic RST_TRANSMIT_END_FLAG = 1'b1;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scsf_bus_s;

  typedef struct packed {
    logic [7:0] data;
    logic parity;
  } scsf_char_s;

  typedef struct packed {
    logic transmit_buffer_empty_flag, error_signal_status_flag, parity_error_flag, transmit_end_flag, transmit_multiprocessor_bit;
    logic arm_transmit_buffer_empty_flag, arm_ers, arm_per;
    logic dir, inv, card_interface_mode_select;
    logic te, gm, block_transfer_mode, odd, seven;
    logic guard_run;
    logic [2:0] guard_cnt;
    logic tx_load;
    scsf_char_s tx;
    logic [7:0] receive_data_register;
    logic [7:0] rd_data;
  } scsf_state_s;
endpackage : scsf_pkg

//--- verilog/scsf_fifo.sv
// Transmit character FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module scsf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr, rd;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } scsf_fifo_state_s;
  scsf_fifo_state_s s_reg, s_next;
  logic push, pop;

  // Output stage counts toward depth so full is honest
  assign in_ready_out = (CW'(s_reg.cnt + CW'(s_reg.ov))) < CW'(DEPTH);
  assign out_valid_out = s_reg.ov;
  assign out_data_out = s_reg.od;
  assign push = in_valid_in && in_ready_out;
  assign pop = s_reg.ov && out_ready_in;

  always_comb begin
    s_next = s_reg;
    if (pop) begin
      s_next.ov = 1'b0;
    end
    if (!s_next.ov && s_reg.cnt != '0) begin
      s_next.od = s_reg.mem[s_reg.rd];
      s_next.ov = 1'b1;
      s_next.rd = s_reg.rd + 1'b1;
      s_next.cnt = s_next.cnt - 1'b1;
    end
    if (push) begin
      if (!s_next.ov && s_reg.cnt == '0) begin
        s_next.od = in_data_in;
        s_next.ov = 1'b1;
      end else begin
        s_next.mem[s_reg.wr] = in_data_in;
        s_next.wr = s_reg.wr + 1'b1;
        s_next.cnt = s_next.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : scsf_fifo
`default_nettype wire

//--- verilog/scsf_char_fmt.sv
// Character bit order, inversion and parity formatter
`timescale 1ns/1ps
`default_nettype none
module scsf_char_fmt (
  // Character and format controls
  input wire logic [7:0] data_in,
  input wire logic seven_bit_in,
  input wire logic msb_first_in,
  input wire logic invert_in,
  input wire logic parity_odd_in,
  // Formatted character
  output logic [7:0] data_out,
  output logic parity_out
);
  logic [7:0] mask;
  logic [7:0] masked;
  logic [7:0] inverted;

  assign mask = seven_bit_in ? 8'h7f : 8'hff;
  assign masked = data_in & mask;
  // Inversion touches data bits only; parity stays on the source value
  assign inverted = invert_in ? (~data_in & mask) : masked;
  // Seven-bit characters always go out LSB first
  assign data_out = (msb_first_in && !seven_bit_in) ? {<<{inverted}} : inverted;
  assign parity_out = (^masked) ^ parity_odd_in;
endmodule : scsf_char_fmt
`default_nettype wire

//--- verilog/scsf_core.sv
// Smart card status flags, format register and transmit path
`timescale 1ns/1ps
`default_nettype none
module scsf_core (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Transmit shifter side
  input wire logic tx_busy_in,
  input wire logic tx_sent_in,
  input wire logic half_etu_tick_in,
  input wire logic err_sig_low_in,
  output logic tx_load_out,
  output logic [7:0] tx_char_out,
  output logic tx_parity_out,
  // Receive shifter side
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_char_in,
  input wire logic rx_parity_err_in,
  // Mode and transmit FIFO full indication
  output logic card_mode_out,
  output logic tdr_full_out
);
  scsf_pkg::scsf_state_s s_reg, s_next;
  scsf_pkg::scsf_bus_s bus;
  scsf_pkg::scsf_char_s fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] tx_fmt_data;
  logic tx_fmt_par;
  logic [7:0] rx_fmt_data;
  logic wr_status, rd_status;
  logic clr_transmit_buffer_empty_flag, clr_ers, clr_per;
  logic guard_done, transmit_end_flag_set;
  logic [7:0] status_val, mode_val, ctrl_val;

  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
  assign wr_status = bus.wr && bus.addr == scsf_pkg::ADDR_STATUS;
  assign rd_status = bus.rd && bus.addr == scsf_pkg::ADDR_STATUS;

  // Only a 0 written after the flag was read as 1 clears it
  assign clr_transmit_buffer_empty_flag = wr_status && s_reg.arm_transmit_buffer_empty_flag && !bus.wdata[scsf_pkg::STS_TRANSMIT_BUFFER_EMPTY_FLAG];
  assign clr_ers = wr_status && s_reg.arm_ers && !bus.wdata[scsf_pkg::STS_ERS];
  assign clr_per = wr_status && s_reg.arm_per && !bus.wdata[scsf_pkg::STS_PER];

  assign guard_done = s_reg.guard_run && half_etu_tick_in && s_reg.guard_cnt == 3'h1;
  assign transmit_end_flag_set = guard_done && !s_reg.error_signal_status_flag && s_reg.transmit_buffer_empty_flag;

  // Hold the drain while the shifter is busy so the FIFO can fill
  assign fifo_pop = s_reg.card_interface_mode_select && s_reg.te && fifo_out_valid && !tx_busy_in && !s_reg.tx_load;

  assign status_val = {s_reg.transmit_buffer_empty_flag, 2'b00, s_reg.error_signal_status_flag, s_reg.parity_error_flag, s_reg.transmit_end_flag,
                       1'b0, s_reg.transmit_multiprocessor_bit};
  assign mode_val = scsf_pkg::MODE_RSVD_ONES | {4'h0, s_reg.dir, s_reg.inv, 1'b0,
                                                 s_reg.card_interface_mode_select};
  assign ctrl_val = {3'h0, s_reg.seven, s_reg.odd, s_reg.block_transfer_mode, s_reg.gm, s_reg.te};

  scsf_char_fmt u_tx_fmt (
    .data_in(bus.wdata),
    .seven_bit_in(s_reg.seven),
    .msb_first_in(s_reg.dir),
    .invert_in(s_reg.inv),
    .parity_odd_in(s_reg.odd),
    .data_out(tx_fmt_data),
    .parity_out(tx_fmt_par)
  );

  scsf_char_fmt u_rx_fmt (
    .data_in(rx_char_in),
    .seven_bit_in(s_reg.seven),
    .msb_first_in(s_reg.dir),
    .invert_in(s_reg.inv),
    .parity_odd_in(s_reg.odd),
    .data_out(rx_fmt_data),
    .parity_out()
  );

  scsf_fifo #(
    .WIDTH(scsf_pkg::DATA_W + 1),
    .DEPTH(scsf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(bus.wr && bus.addr == scsf_pkg::ADDR_TDR),
    .in_ready_out(fifo_in_ready),
    .in_data_in({tx_fmt_data, tx_fmt_par}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out)
  );

  always_comb begin
    s_next = s_reg;
    s_next.tx_load = 1'b0;
    s_next.rd_data = 8'h00;
    // Register writes
    if (bus.wr) begin
      if (bus.addr == scsf_pkg::ADDR_STATUS) begin
        s_next.transmit_multiprocessor_bit = bus.wdata[scsf_pkg::STS_TRANSMIT_MULTIPROCESSOR_BIT];
        s_next.arm_transmit_buffer_empty_flag = 1'b0;
        s_next.arm_ers = 1'b0;
        s_next.arm_per = 1'b0;
      end else if (bus.addr == scsf_pkg::ADDR_MODE) begin
        s_next.dir = bus.wdata[scsf_pkg::MODE_DIR];
        s_next.inv = bus.wdata[scsf_pkg::MODE_INV];
        s_next.card_interface_mode_select = bus.wdata[scsf_pkg::MODE_CARD_INTERFACE_MODE_SELECT];
      end else if (bus.addr == scsf_pkg::ADDR_CTRL) begin
        s_next.te = bus.wdata[scsf_pkg::CTRL_TE];
        s_next.gm = bus.wdata[scsf_pkg::CTRL_GM];
        s_next.block_transfer_mode = bus.wdata[scsf_pkg::CTRL_BLK];
        s_next.odd = bus.wdata[scsf_pkg::CTRL_ODD];
        s_next.seven = bus.wdata[scsf_pkg::CTRL_SEVEN];
      end
    end
    // Register reads, data in the following cycle
    if (bus.rd) begin
      if (bus.addr == scsf_pkg::ADDR_RDR) begin
        s_next.rd_data = s_reg.receive_data_register;
      end else if (bus.addr == scsf_pkg::ADDR_STATUS) begin
        s_next.rd_data = status_val;
      end else if (bus.addr == scsf_pkg::ADDR_MODE) begin
        s_next.rd_data = mode_val;
      end else if (bus.addr == scsf_pkg::ADDR_CTRL) begin
        s_next.rd_data = ctrl_val;
      end
    end
    // Arm clearing on a read that saw the flag at 1
    if (rd_status) begin
      s_next.arm_transmit_buffer_empty_flag = s_reg.transmit_buffer_empty_flag;
      s_next.arm_ers = s_reg.error_signal_status_flag;
      s_next.arm_per = s_reg.parity_error_flag;
    end
    // Flag clears first, hardware sets below win
    if (clr_transmit_buffer_empty_flag) begin
      s_next.transmit_buffer_empty_flag = 1'b0;
      s_next.transmit_end_flag = 1'b0;
    end
    if (clr_ers) begin
      s_next.error_signal_status_flag = 1'b0;
    end
    if (clr_per) begin
      s_next.parity_error_flag = 1'b0;
    end
    // Guard interval timer after each character
    if (s_reg.card_interface_mode_select && tx_sent_in) begin
      s_next.guard_run = 1'b1;
      if (s_reg.gm) begin
        s_next.guard_cnt = scsf_pkg::HALF_ETU_GUARD;
      end else if (s_reg.block_transfer_mode) begin
        s_next.guard_cnt = scsf_pkg::HALF_ETU_BLOCK;
      end else begin
        s_next.guard_cnt = scsf_pkg::HALF_ETU_NORMAL;
      end
    end else if (s_reg.guard_run && half_etu_tick_in) begin
      s_next.guard_cnt = s_reg.guard_cnt - 3'h1;
      if (s_reg.guard_cnt == 3'h1) begin
        s_next.guard_run = 1'b0;
      end
    end
    if (transmit_end_flag_set) begin
      s_next.transmit_end_flag = 1'b1;
    end
    if (!s_reg.te && !s_reg.error_signal_status_flag) begin
      s_next.transmit_end_flag = 1'b1;
    end
    if (!s_reg.te) begin
      s_next.transmit_buffer_empty_flag = 1'b1;
    end
    if (fifo_pop) begin
      s_next.tx_load = 1'b1;
      s_next.tx = fifo_out;
      s_next.transmit_buffer_empty_flag = 1'b1;
    end
    if (s_reg.card_interface_mode_select && err_sig_low_in) begin
      s_next.error_signal_status_flag = 1'b1;
    end
    if (rx_valid_in) begin
      s_next.receive_data_register = rx_fmt_data;
      if (s_reg.card_interface_mode_select && rx_parity_err_in) begin
        s_next.parity_error_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      s_reg.transmit_buffer_empty_flag <= scsf_pkg::RST_TRANSMIT_BUFFER_EMPTY_FLAG;
      s_reg.transmit_end_flag <= scsf_pkg::RST_TRANSMIT_END_FLAG;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_out = s_reg.rd_data;
  assign tx_load_out = s_reg.tx_load;
  assign tx_char_out = s_reg.tx.data;
  assign tx_parity_out = s_reg.tx.parity;
  assign card_mode_out = s_reg.card_interface_mode_select;

  // Registered view of FIFO back-pressure for software
  logic tdr_full_reg;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tdr_full_reg <= 1'b0;
    end else begin
      tdr_full_reg <= !fifo_in_ready;
    end
  end
  assign tdr_full_out = tdr_full_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_per_sets: assert property (
    rx_valid_in && rx_parity_err_in && s_reg.card_interface_mode_select |=> s_reg.parity_error_flag)
    else $error("parity error flag not set");

  a_per_no_read: assert property (
    s_reg.parity_error_flag && wr_status && !s_reg.arm_per |=> s_reg.parity_error_flag)
    else $error("parity error cleared without prior read");

  a_flag_write_one: assert property (
    s_reg.error_signal_status_flag && wr_status && bus.wdata[scsf_pkg::STS_ERS] |=> s_reg.error_signal_status_flag)
    else $error("writing 1 cleared error signal flag");

  a_transmit_end_flag_idle_hold: assert property (
    !s_reg.te && !s_reg.error_signal_status_flag |=> s_reg.transmit_end_flag)
    else $error("transmit end not held while idle");

  a_transmit_end_flag_cause: assert property (
    $rose(s_reg.transmit_end_flag) && $past(s_reg.te) |-> $past(s_reg.transmit_buffer_empty_flag) && !$past(s_reg.error_signal_status_flag))
    else $error("transmit end rose without its condition");

  // Start count per mode; ticks are not back to back, so check start and end apart
  a_guard_length: assert property (
    s_reg.card_interface_mode_select && tx_sent_in |=> s_reg.guard_run && s_reg.guard_cnt == ($past(s_reg.gm)
    ? scsf_pkg::HALF_ETU_GUARD : ($past(s_reg.block_transfer_mode) ? scsf_pkg::HALF_ETU_BLOCK
    : scsf_pkg::HALF_ETU_NORMAL)))
    else $error("guard interval start count wrong");

  a_guard_end: assert property (
    s_reg.guard_run && half_etu_tick_in && s_reg.guard_cnt == 3'h1 && !tx_sent_in
    |=> !s_reg.guard_run)
    else $error("guard interval did not end on last tick");

  // Count moves only on half-etu ticks
  a_guard_step: assert property (
    s_reg.guard_run && !tx_sent_in && !half_etu_tick_in
    |=> s_reg.guard_run && $stable(s_reg.guard_cnt))
    else $error("guard count moved without a tick");

  a_transmit_end_flag_on_guard: assert property (
    s_reg.guard_run && half_etu_tick_in && s_reg.guard_cnt == 3'h1 && s_reg.transmit_buffer_empty_flag
    && !s_reg.error_signal_status_flag |=> s_reg.transmit_end_flag)
    else $error("transmit end not set after guard interval");

  a_transmit_end_flag_clear: assert property (
    clr_transmit_buffer_empty_flag && !transmit_end_flag_set && s_reg.te |=> !s_reg.transmit_end_flag)
    else $error("transmit end not cleared with buffer empty flag");

  a_mpb_zero: assert property (
    $past(rd_status) |-> !reg_rdata_out[scsf_pkg::STS_MPB])
    else $error("received multiprocessor bit not zero");

  a_mode_reserved: assert property (
    $past(bus.rd && bus.addr == scsf_pkg::ADDR_MODE)
    |-> (reg_rdata_out & scsf_pkg::MODE_RSVD_ONES) == scsf_pkg::MODE_RSVD_ONES)
    else $error("reserved mode bits not read as one");

  a_no_load_normal: assert property (
    !s_reg.card_interface_mode_select |=> !tx_load_out)
    else $error("character loaded outside smart card mode");

  a_ers_sets: assert property (
    s_reg.card_interface_mode_select && err_sig_low_in |=> s_reg.error_signal_status_flag ##1 s_reg.error_signal_status_flag || $past(clr_ers))
    else $error("error signal flag not set");

  a_transmit_buffer_empty_flag_on_load: assert property (
    fifo_pop |=> s_reg.transmit_buffer_empty_flag && tx_load_out ##1 !tx_load_out)
    else $error("buffer empty flag or load pulse wrong");

  a_per_clear: assert property (
    clr_per && !rx_valid_in |=> !s_reg.parity_error_flag)
    else $error("parity error not cleared after read and write 0");

  a_per_write_one: assert property (
    s_reg.parity_error_flag && wr_status && bus.wdata[scsf_pkg::STS_PER] |=> s_reg.parity_error_flag)
    else $error("writing 1 cleared parity error flag");

  a_transmit_buffer_empty_flag_no_read: assert property (
    s_reg.transmit_buffer_empty_flag && wr_status && !s_reg.arm_transmit_buffer_empty_flag |=> s_reg.transmit_buffer_empty_flag)
    else $error("buffer empty flag cleared without prior read");

  a_mode_write: assert property (
    bus.wr && bus.addr == scsf_pkg::ADDR_MODE
    |=> card_mode_out == $past(bus.wdata[scsf_pkg::MODE_CARD_INTERFACE_MODE_SELECT]))
    else $error("card mode select not taken from write");

  // Seven-bit characters ignore the order select
  a_seven_lsb: assert property (
    bus.wr && bus.addr == scsf_pkg::ADDR_TDR && s_reg.seven && !s_reg.inv
    |-> tx_fmt_data == {1'b0, bus.wdata[6:0]})
    else $error("seven-bit character reordered");

  a_rdr_invert: assert property (
    rx_valid_in && s_reg.inv && !(s_reg.dir && !s_reg.seven)
    |=> s_reg.receive_data_register == (~$past(rx_char_in) & ($past(s_reg.seven) ? 8'h7f : 8'hff)))
    else $error("received character not stored inverted");

  c_parity_err: cover property (rx_valid_in && rx_parity_err_in && s_reg.card_interface_mode_select);
  c_transmit_end_flag_rise: cover property (transmit_end_flag_set);
  c_guard_done: cover property (guard_done && s_reg.gm);
  c_fifo_full: cover property (!fifo_in_ready);
  c_ers_then_clear: cover property (s_reg.error_signal_status_flag ##[1:20] clr_ers);
endmodule : scsf_core
`default_nettype wire

//--- tb/scsf_card_model.sv
// Shifter and card stand-in on the far side of the transmit path
`timescale 1ns/1ps
`default_nettype none
module scsf_card_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Commands from the bench
  input wire logic slow_in,
  input wire logic err_mode_in,
  // Core side
  input wire logic tx_load_in,
  output logic busy_out,
  output logic sent_out,
  output logic tick_out,
  output logic err_low_out
);
  logic [1:0] phase_reg;
  logic [4:0] cnt_reg;
  assign tick_out = (phase_reg == 2'h3);
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      phase_reg <= 2'h0;
      cnt_reg <= 5'h00;
      busy_out <= 1'b0;
      sent_out <= 1'b0;
      err_low_out <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      sent_out <= 1'b0;
      // Card pulls the error level only when told to reject
      err_low_out <= sent_out & err_mode_in;
      if (tx_load_in) begin
        busy_out <= 1'b1;
        cnt_reg <= slow_in ? 5'h14 : 5'h06;
      end else if (busy_out && cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end else if (busy_out && phase_reg == 2'h1) begin
        // End kept off tick cycles so guard counts are exact
        busy_out <= 1'b0;
        sent_out <= 1'b1;
      end
    end
  end
endmodule : scsf_card_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the smart card status and format core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic rx_valid_in = 1'b0;
  logic [7:0] rx_char_in = 8'h00;
  logic rx_parity_err_in = 1'b0;
  logic slow = 1'b0;
  logic err_mode = 1'b0;
  logic [7:0] reg_rdata_out, tx_char_out;
  logic tx_load_out, tx_parity_out, card_mode_out, tdr_full_out;
  logic busy, sent, tick, err_low;
  logic [16:0] txq[$];
  logic [16:0] mon_e;
  int ticks = 0;
  int failures = 0;
  int total_checks = 0;

  scsf_core uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .tx_busy_in(busy), .tx_sent_in(sent),
    .half_etu_tick_in(tick), .err_sig_low_in(err_low), .tx_load_out(tx_load_out),
    .tx_char_out(tx_char_out), .tx_parity_out(tx_parity_out), .rx_valid_in(rx_valid_in),
    .rx_char_in(rx_char_in), .rx_parity_err_in(rx_parity_err_in),
    .card_mode_out(card_mode_out), .tdr_full_out(tdr_full_out));
  scsf_card_model card (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .slow_in(slow),
    .err_mode_in(err_mode), .tx_load_in(tx_load_out), .busy_out(busy), .sent_out(sent),
    .tick_out(tick), .err_low_out(err_low));

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobes are reassigned every cycle, so none is set twice in a step
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, 8'h00);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    d = reg_rdata_out;
  endtask : rd

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  task automatic rx(input logic [7:0] b, input logic bad);
    rx_valid_in <= 1'b1;
    rx_char_in <= b;
    rx_parity_err_in <= bad;
    @(posedge mclk_in);
    rx_valid_in <= 1'b0;
    @(posedge mclk_in);
  endtask : rx

  task automatic reset_dut();
    rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    txq.delete();
    @(posedge mclk_in);
  endtask : reset_dut

  // Packs parity, compare mask and formatted data
  function automatic logic [16:0] expect_tx(logic [7:0] v, logic [7:0] m, logic [7:0] c);
    logic [7:0] k;
    logic [7:0] d;
    logic [7:0] r;
    k = c[4] ? 8'h7f : 8'hff;
    d = v & k;
    for (int i = 0; i < 8; i++) r[i] = d[7-i];
    if (m[3] && !c[4]) d = r;
    if (m[2]) d = ~d;
    return {^(v & k) ^ c[3], k, d & k};
  endfunction : expect_tx

  always @(posedge mclk_in) begin
    if (sent) ticks <= 0;
    else if (tick) ticks <= ticks + 1;
  end

  always @(posedge mclk_in) begin
    if (rst_n_in && tx_load_out === 1'b1) begin
      if (txq.size() == 0) begin
        chk(8'h01, 8'h00);
      end else begin
        mon_e = txq.pop_front();
        chk(tx_char_out & mon_e[15:8], mon_e[7:0]);
        chk({7'h0, tx_parity_out}, {7'h0, mon_e[16]});
      end
    end
  end

  initial begin
    repeat (60000) @(posedge mclk_in);
    failures++;
    wrap_up();
  end

  initial begin
    logic [7:0] v, m, c, d;
    logic [16:0] e;
    void'($urandom(45));
    reset_dut();
    rdchk(scsf_pkg::ADDR_STATUS, 8'h84);
    rdchk(scsf_pkg::ADDR_MODE, 8'hf2);
    rdchk(3'h7, 8'h00);
    wr(3'h7, 8'hff);
    for (int n = 0; n < 4; n++) begin
      v = 8'($urandom) ^ 8'(n);
      wr(scsf_pkg::ADDR_MODE, v);
      rdchk(scsf_pkg::ADDR_MODE, 8'hf2 | (v & 8'h0d));
      chk({7'h0, card_mode_out}, {7'h0, v[0]});
    end
    wr(scsf_pkg::ADDR_MODE, 8'h01);
    rd(scsf_pkg::ADDR_STATUS, d);
    wr(scsf_pkg::ADDR_STATUS, 8'h00);
    rdchk(scsf_pkg::ADDR_STATUS, 8'h84);
    rx(8'h5a, 1'b1);
    wr(scsf_pkg::ADDR_STATUS, 8'h00);
    rdchk(scsf_pkg::ADDR_STATUS, 8'h8c);
    wr(scsf_pkg::ADDR_STATUS, 8'hfe);
    rdchk(scsf_pkg::ADDR_STATUS, 8'h8c);
    wr(scsf_pkg::ADDR_STATUS, 8'h00);
    rdchk(scsf_pkg::ADDR_STATUS, 8'h84);
    wr(scsf_pkg::ADDR_MODE, 8'h00);
    rx(8'h33, 1'b1);
    rdchk(scsf_pkg::ADDR_STATUS, 8'h84);
    for (int n = 0; n < 6; n++) begin
      v = 8'($urandom);
      m = 8'($urandom) | 8'h01;
      c = 8'($urandom) & 8'h10;
      wr(scsf_pkg::ADDR_MODE, m);
      wr(scsf_pkg::ADDR_CTRL, c);
      rx(v, 1'b0);
      e = expect_tx(v, m, c);
      rd(scsf_pkg::ADDR_RDR, d);
      chk(d & e[15:8], e[7:0]);
    end
    // Seventeen pushes with TE off: the last must be dropped
    reset_dut();
    for (int n = 0; n < 17; n++) begin
      v = 8'($urandom);
      m = (8'($urandom) & 8'h0c) | 8'h01;
      c = 8'($urandom) & 8'h1e;
      wr(scsf_pkg::ADDR_MODE, m);
      wr(scsf_pkg::ADDR_CTRL, c);
      wr(scsf_pkg::ADDR_TDR, v);
      if (n < 16) txq.push_back(expect_tx(v, m, c));
    end
    chk({7'h0, tdr_full_out}, 8'h01);
    slow <= 1'b1;
    wr(scsf_pkg::ADDR_CTRL, 8'h01);
    for (int n = 0; n < 3000 && txq.size() > 0; n++) @(posedge mclk_in);
    chk(8'(txq.size()), 8'h00);
    chk({7'h0, tdr_full_out}, 8'h00);
    slow <= 1'b0;
    for (int n = 0; n < 5; n++) begin
      reset_dut();
      err_mode <= (n == 4);
      c = 8'h01 | 8'((n % 4) * 2);
      wr(scsf_pkg::ADDR_MODE, 8'h01);
      wr(scsf_pkg::ADDR_CTRL, c);
      rd(scsf_pkg::ADDR_STATUS, d);
      wr(scsf_pkg::ADDR_STATUS, 8'h00);
      rdchk(scsf_pkg::ADDR_STATUS, 8'h00);
      v = 8'($urandom);
      txq.push_back(expect_tx(v, 8'h01, c));
      wr(scsf_pkg::ADDR_TDR, v);
      d = 8'h00;
      // Stop on transmit end, or on the card's error signal in the reject pass
      for (int i = 0; i < 60 && d[2] !== 1'b1 && d[4] !== 1'b1; i++) begin
        rd(scsf_pkg::ADDR_STATUS, d);
      end
      if (n == 4) begin
        chk(d, 8'h90);
        // Transmit end must stay low past the end of the guard interval
        repeat (40) @(posedge mclk_in);
        rdchk(scsf_pkg::ADDR_STATUS, 8'h90);
        wr(scsf_pkg::ADDR_STATUS, 8'h10);
        rdchk(scsf_pkg::ADDR_STATUS, 8'h10);
        wr(scsf_pkg::ADDR_STATUS, 8'h00);
        rdchk(scsf_pkg::ADDR_STATUS, 8'h00);
      end else begin
        chk(d, 8'h84);
        chk(8'(ticks), c[1] ? 8'h02 : (c[2] ? 8'h03 : 8'h05));
      end
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
